// File: core/bad_bit_decode.v
// Direct bit-address decoder with the bit-addressable status and control registers.
`timescale 1ns/1ps
`include "bad_map.vh"

// Notes on behaviour
// - Bit addresses 00h-7Fh select RAM bytes 20h-2Fh, bit 0 of 20h first.
// - Addresses 80h-FFh pick the register sharing upper five bits; low three bits pick bit.
// - Carry is bit 7 of the status word, reachable as any addressable bit.
// - Aux carry in status bit 6 follows carry/borrow out of bit 3 on add/sub.
// - Status bit 5 is a software flag that hardware never alters.
// - Status bits 4:3 choose register bank 0..3 at RAM 00h, 08h, 10h, 18h.
// - Overflow in status bit 2 updates on arithmetic; status bit 1 is reserved.
// - Parity in status bit 0 is refreshed each cycle, one for odd accumulator ones.
// - Port 3 bits 7 and 6 pulse low for external data read and write.
// - Port 3 bit 0 is receive input in async modes, bidirectional data in shift mode.
// - Timer control bits 7 and 5 set on timer overflow, cleared on interrupt service.
// - Timer control bits 6 and 4 are software run controls for timers 1 and 0.
// - Timer control bits 3 and 1 set on external interrupt edge only in edge mode, cleared on service.
// - Timer control bits 2 and 0 choose falling edge (1) or low level (0).
// - Serial control bits 7:6 select shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Serial control bit 5 makes receiver drop frames whose ninth bit is zero, except in shift mode.
// - Serial control bit 4 enables serial reception.
// - Serial control bit 3 gives the ninth transmitted bit in 9-bit modes.
// - Serial control bit 0 is set by hardware on receive; only software clears it.
// - Clearing enable bit 7 masks all interrupts; enable bits 6 and 5 are reserved.
// - Enable bit 4 gates serial interrupts, bit 3 gates timer 1 interrupts.
// - Priority bit 4 raises serial, bit 3 raises timer 1; bits 7:5 reserved.
module bad_bit_decode (
   input wire clk,
   input wire reset,
   input wire [7:0] bit_addr,
   input wire [1:0] bit_op,
   input wire bit_wdata,
   output reg bit_rdata,
   output reg bit_addr_valid,
   input wire [7:0] byte_addr,
   input wire byte_wr,
   input wire [7:0] byte_wdata,
   output reg [7:0] byte_rdata,
   input wire [7:0] acc_value,
   input wire arith_update,
   input wire arith_carry,
   input wire arith_aux_carry,
   input wire arith_overflow,
   input wire timer1_overflow,
   input wire timer0_overflow,
   input wire int1_serviced,
   input wire int0_serviced,
   input wire ext_int1_n_pin,
   input wire ext_int0_n_pin,
   input wire rx_byte_done,
   input wire rx_ninth_bit,
   input wire xdata_rd,
   input wire xdata_wr,
   input wire rx_data_pin_in,
   input wire shift_data_out,
   input wire shift_data_oe,
   output reg rx_data_pin_out,
   output reg rx_data_pin_oe,
   output reg rx_serial_in,
   output reg read_strobe_n,
   output reg write_strobe_n,
   output wire [1:0] bank_select,
   output wire [4:0] bank_base,
   output wire timer1_run,
   output wire timer0_run,
   output wire [1:0] serial_mode,
   output wire rx_enable,
   output wire rx_accept,
   output wire tx_ninth_bit,
   output wire int1_request,
   output wire int0_request,
   output wire timer1_int_req,
   output wire serial_int_req,
   output wire timer1_high_prio,
   output wire serial_high_prio
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Bit-addressable RAM bytes 20h to 2Fh, indexed by the low nibble.
   reg [7:0] ram_q [0:15];
   reg [7:0] program_status_word_q;
   reg [7:0] timer_control_status_q;
   reg [7:0] serial_control_status_q;
   reg [7:0] interrupt_enable_q;
   reg [7:0] interrupt_priority_q;
   reg [7:0] acc_byte_q;
   reg [7:0] b_byte_q;
   reg [7:0] port_q [0:3];
   reg int1_meta_q;
   reg int1_sync_q;
   reg int1_prev_q;
   reg int0_meta_q;
   reg int0_sync_q;
   reg int0_prev_q;
   reg rxd_meta_q;
   reg rxd_sync_q;
   // Combinational results of the bit access path.
   reg [7:0] tgt_byte;
   reg tgt_hit;
   reg [7:0] bit_new;
   reg [7:0] sel_addr;
   integer i;

   // Decode of a bit address into a byte address, the RAM region first.
   function [7:0] bit_to_byte;
      input [7:0] a;
      begin
         if (a[7] == 1'b0) begin
            bit_to_byte = `BAD_RAM_BASE + {4'h0, a[6:3]};
         end else begin
            bit_to_byte = {a[7:3], 3'b000};
         end
      end
   endfunction

   // Byte value with one bit replaced, neighbours kept.
   function [7:0] merge_bit;
      input [7:0] old;
      input [2:0] pos;
      input val;
      reg [7:0] m;
      begin
         m = 8'h01 << pos;
         merge_bit = val ? (old | m) : (old & ~m);
      end
   endfunction

   // Read mux for the whole byte space this block owns.
   function [8:0] byte_read;
      input [7:0] a;
      begin
         if (a >= `BAD_RAM_BASE && a < `BAD_RAM_BASE + 8'h10) begin
            byte_read = {1'b1, ram_q[a[3:0]]};
         end else if (a == `BAD_SFR_PSW) begin
            byte_read = {1'b1, program_status_word_q};
         end else if (a == `BAD_SFR_TCS) begin
            byte_read = {1'b1, timer_control_status_q};
         end else if (a == `BAD_SFR_SCS) begin
            byte_read = {1'b1, serial_control_status_q};
         end else if (a == `BAD_SFR_IEN) begin
            byte_read = {1'b1, interrupt_enable_q & ~`BAD_IEN_RSV_MASK};
         end else if (a == `BAD_SFR_IPR) begin
            byte_read = {1'b1, interrupt_priority_q & ~`BAD_IPR_RSV_MASK};
         end else if (a == `BAD_SFR_ACC) begin
            byte_read = {1'b1, acc_byte_q};
         end else if (a == `BAD_SFR_BREG) begin
            byte_read = {1'b1, b_byte_q};
         end else if (a == `BAD_SFR_P0 || a == `BAD_SFR_P1 || a == `BAD_SFR_P2 || a == `BAD_SFR_P3) begin
            byte_read = {1'b1, port_q[a[5:4]]};
         end else begin
            byte_read = 9'h000;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Bit access path
   // ----------------------------------------------------------------

   // Target byte of the current bit operation and its modified value.
   always @* begin
      sel_addr = bit_to_byte(bit_addr);
      {tgt_hit, tgt_byte} = byte_read(sel_addr);
      case (bit_op)
         `BAD_OP_SET: bit_new = merge_bit(tgt_byte, bit_addr[2:0], 1'b1);
         `BAD_OP_CLR: bit_new = merge_bit(tgt_byte, bit_addr[2:0], 1'b0);
         `BAD_OP_WRITE: bit_new = merge_bit(tgt_byte, bit_addr[2:0], bit_wdata);
         default: bit_new = tgt_byte;
      endcase
   end

   // Byte read word; the top bit only marks a hit and is not returned.
   wire [8:0] byte_rd_word = byte_read(byte_addr);

   // Registered read data of the addressed bit and the whole byte.
   always @(posedge clk) begin
      if (reset) begin
         bit_rdata <= 1'b0;
         bit_addr_valid <= 1'b0;
         byte_rdata <= `BAD_RESET_BYTE;
      end else begin
         bit_rdata <= tgt_byte[bit_addr[2:0]];
         bit_addr_valid <= tgt_hit;
         byte_rdata <= byte_rd_word[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------

   // Two flip-flops on each pin before any logic reads it; all stages start at
   // the idle high level so that leaving reset never fakes a falling edge.
   always @(posedge clk) begin
      if (reset) begin
         int1_meta_q <= 1'b1;
         int1_sync_q <= 1'b1;
         int1_prev_q <= 1'b1;
         int0_meta_q <= 1'b1;
         int0_sync_q <= 1'b1;
         int0_prev_q <= 1'b1;
         rxd_meta_q <= 1'b1;
         rxd_sync_q <= 1'b1;
      end else begin
         int1_meta_q <= ext_int1_n_pin;
         int1_sync_q <= int1_meta_q;
         int1_prev_q <= int1_sync_q;
         int0_meta_q <= ext_int0_n_pin;
         int0_sync_q <= int0_meta_q;
         int0_prev_q <= int0_sync_q;
         rxd_meta_q <= rx_data_pin_in;
         rxd_sync_q <= rxd_meta_q;
      end
   end

   // Falling edges of the synchronised external interrupt pins.
   wire int1_fall = int1_prev_q & ~int1_sync_q;
   wire int0_fall = int0_prev_q & ~int0_sync_q;

   // ----------------------------------------------------------------
   // Register updates: software byte write, then bit op, then hardware
   // ----------------------------------------------------------------
   // A bit operation only writes when it lands on an implemented byte.
   wire bit_wr = (bit_op != `BAD_OP_NONE) && tgt_hit;
   // Next accumulator value; parity must follow it in the same cycle.
   // The bit path wins over a byte write, as for every other byte.
   wire [7:0] acc_next = (bit_wr && sel_addr == `BAD_SFR_ACC) ? bit_new :
                         (byte_wr && byte_addr == `BAD_SFR_ACC) ? byte_wdata : acc_byte_q;

   // Software write helper: byte write wins over nothing, bit op over the byte path.
   function [7:0] sw_next;
      input [7:0] a;
      input [7:0] cur;
      begin
         if (bit_wr && sel_addr == a) begin
            sw_next = bit_new;
         end else if (byte_wr && byte_addr == a) begin
            sw_next = byte_wdata;
         end else begin
            sw_next = cur;
         end
      end
   endfunction

   // All software-visible storage; hardware side effects are applied after the
   // software path, so a hardware set beats a software clear in one cycle.
   always @(posedge clk) begin
      if (reset) begin
         program_status_word_q <= `BAD_RESET_BYTE;
         timer_control_status_q <= `BAD_RESET_BYTE;
         serial_control_status_q <= `BAD_RESET_BYTE;
         interrupt_enable_q <= `BAD_RESET_BYTE;
         interrupt_priority_q <= `BAD_RESET_BYTE;
         acc_byte_q <= `BAD_RESET_BYTE;
         b_byte_q <= `BAD_RESET_BYTE;
         for (i = 0; i < 16; i = i + 1) begin
            ram_q[i] <= `BAD_RESET_BYTE;
         end
         // Port latches leave reset at all ones.
         for (i = 0; i < 4; i = i + 1) begin
            port_q[i] <= 8'hff;
         end
      end else begin
         // RAM bytes and ports take software writes only.
         for (i = 0; i < 16; i = i + 1) begin
            ram_q[i] <= sw_next(`BAD_RAM_BASE + i[7:0], ram_q[i]);
         end
         port_q[0] <= sw_next(`BAD_SFR_P0, port_q[0]);
         port_q[1] <= sw_next(`BAD_SFR_P1, port_q[1]);
         port_q[2] <= sw_next(`BAD_SFR_P2, port_q[2]);
         port_q[3] <= sw_next(`BAD_SFR_P3, port_q[3]);
         acc_byte_q <= acc_next;
         b_byte_q <= sw_next(`BAD_SFR_BREG, b_byte_q);
         interrupt_enable_q <= sw_next(`BAD_SFR_IEN, interrupt_enable_q) & ~`BAD_IEN_RSV_MASK;
         interrupt_priority_q <= sw_next(`BAD_SFR_IPR, interrupt_priority_q) & ~`BAD_IPR_RSV_MASK;
         // Status word: bit 5 and bank bits only ever come from software.
         program_status_word_q <= psw_hw(sw_next(`BAD_SFR_PSW, program_status_word_q));
         timer_control_status_q <= tcs_hw(sw_next(`BAD_SFR_TCS, timer_control_status_q));
         serial_control_status_q <= scs_hw(sw_next(`BAD_SFR_SCS, serial_control_status_q));
      end
   end

   // Hardware side effects on the status word.
   function [7:0] psw_hw;
      input [7:0] v;
      reg [7:0] r;
      begin
         r = v & ~`BAD_PSW_RSV_MASK;
         if (arith_update) begin
            r[`BAD_PSW_CY] = arith_carry;
            r[`BAD_PSW_AC] = arith_aux_carry;
            r[`BAD_PSW_OV] = arith_overflow;
         end
         r[`BAD_PSW_PAR] = ^acc_next;
         psw_hw = r;
      end
   endfunction

   // Hardware flags of timer control; an event beats a clear in the same cycle.
   function [7:0] tcs_hw;
      input [7:0] v;
      reg [7:0] r;
      begin
         r = v;
         if (int1_serviced) r[`BAD_TCS_TF1] = 1'b0;
         if (int0_serviced) r[`BAD_TCS_TF0] = 1'b0;
         if (int1_serviced) r[`BAD_TCS_EF1] = 1'b0;
         if (int0_serviced) r[`BAD_TCS_EF0] = 1'b0;
         if (timer1_overflow) r[`BAD_TCS_TF1] = 1'b1;
         if (timer0_overflow) r[`BAD_TCS_TF0] = 1'b1;
         if (v[2] && int1_fall) r[`BAD_TCS_EF1] = 1'b1;
         if (v[0] && int0_fall) r[`BAD_TCS_EF0] = 1'b1;
         tcs_hw = r;
      end
   endfunction

   // Receive-done flag: set by hardware, never cleared here, set wins over software.
   function [7:0] scs_hw;
      input [7:0] v;
      reg [7:0] r;
      begin
         r = v;
         if (rx_accept) r[`BAD_SCS_RX_DONE] = 1'b1;
         scs_hw = r;
      end
   endfunction

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   // Register fields straight out to the core and peripherals.
   assign bank_select = program_status_word_q[4:3];
   assign bank_base = {bank_select, 3'b000};
   assign timer1_run = timer_control_status_q[6];
   assign timer0_run = timer_control_status_q[4];
   assign serial_mode = serial_control_status_q[7:6];
   assign rx_enable = serial_control_status_q[4];
   assign rx_accept = rx_byte_done && rx_enable &&
                      !(serial_control_status_q[5] && serial_mode != `BAD_SM_SHIFT && !rx_ninth_bit);
   assign tx_ninth_bit = serial_control_status_q[3];

   // Interrupt requests: edge flag, or a low level when level mode is chosen.
   wire int1_src = timer_control_status_q[2] ? timer_control_status_q[3] : ~int1_sync_q;
   wire int0_src = timer_control_status_q[0] ? timer_control_status_q[1] : ~int0_sync_q;
   // Enable bit 7 masks every request below.
   wire global_int_enable = interrupt_enable_q[7];
   assign int1_request = global_int_enable & interrupt_enable_q[2] & int1_src;
   assign int0_request = global_int_enable & interrupt_enable_q[0] & int0_src;
   assign timer1_int_req = global_int_enable & interrupt_enable_q[3] & timer_control_status_q[7];
   assign serial_int_req = global_int_enable & interrupt_enable_q[4] & serial_control_status_q[0];
   assign serial_high_prio = interrupt_priority_q[4];
   assign timer1_high_prio = interrupt_priority_q[3];

   // Strobes and serial data pin, registered.
   always @(posedge clk) begin
      if (reset) begin
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         rx_data_pin_out <= 1'b1;
         rx_data_pin_oe <= 1'b0;
         rx_serial_in <= 1'b1;
      end else begin
         read_strobe_n <= ~xdata_rd;
         write_strobe_n <= ~xdata_wr;
         rx_data_pin_out <= shift_data_out;
         rx_data_pin_oe <= (serial_mode == `BAD_SM_SHIFT) & shift_data_oe;
         rx_serial_in <= rxd_sync_q;
      end
   end

endmodule // bad_bit_decode

// File: core/bad_map.vh
// Register addresses, bit positions and codes of the bit-address decoder.
`ifndef BAD_MAP_VH
`define BAD_MAP_VH
`define BAD_RAM_BASE 8'h20
`define BAD_SFR_P0 8'h80
`define BAD_SFR_TCS 8'h88
`define BAD_SFR_P1 8'h90
`define BAD_SFR_SCS 8'h98
`define BAD_SFR_P2 8'ha0
`define BAD_SFR_IEN 8'ha8
`define BAD_SFR_P3 8'hb0
`define BAD_SFR_IPR 8'hb8
`define BAD_SFR_PSW 8'hd0
`define BAD_SFR_ACC 8'he0
`define BAD_SFR_BREG 8'hf0
`define BAD_PSW_CY 3'd7
`define BAD_PSW_AC 3'd6
`define BAD_PSW_OV 3'd2
`define BAD_PSW_PAR 3'd0
`define BAD_PSW_RSV_MASK 8'h02
`define BAD_TCS_TF1 3'd7
`define BAD_TCS_TF0 3'd5
`define BAD_TCS_EF1 3'd3
`define BAD_TCS_EF0 3'd1
`define BAD_SCS_RX_DONE 3'd0
`define BAD_IEN_RSV_MASK 8'h60
`define BAD_IPR_RSV_MASK 8'he0
`define BAD_RESET_BYTE 8'h00
`define BAD_OP_NONE 2'd0
`define BAD_OP_SET 2'd1
`define BAD_OP_CLR 2'd2
`define BAD_OP_WRITE 2'd3
`define BAD_SM_SHIFT 2'b00
`endif

// File: tb/bad_core_model.sv
// Behavioural model of the core and peripherals driving the decoder's event inputs.
`timescale 1ns/1ps
// ----
// Core model
// ----
module bad_core_model (
   input wire clk,
   output reg [7:0] ev,
   output reg [3:0] arith,
   output reg [2:0] pins
);
   // Event lines idle low, external pins idle high (pulled up).
   initial begin
      ev = 8'h00;
      arith = 4'h0;
      pins = 3'h7;
   end
   // One-cycle pulse on an event line, changed just after rising edges.
   task pulse(input integer i);
      begin
         @(posedge clk) ev[i] <= 1'b1;
         @(posedge clk) ev[i] <= 1'b0;
      end
   endtask
   // Holds a level such as the received ninth bit.
   task set_lvl(input integer i, input v);
      @(posedge clk) ev[i] <= v;
   endtask
   // Arithmetic flags {carry, aux, overflow} with their update pulse.
   task arith_op(input [2:0] f);
      begin
         @(posedge clk) arith <= {1'b1, f};
         @(posedge clk) arith <= 4'h0;
      end
   endtask
   // Drives an external pin level until changed again.
   task set_pin(input integer i, input v);
      @(posedge clk) pins[i] <= v;
   endtask
endmodule // bad_core_model

// File: tb/bad_checker.sv
// Concurrent checks on the ports of the bit-address decoder.
`timescale 1ns/1ps
`include "bad_map.vh"
// ----
// Checker
// ----
module bad_checker (
   input wire clk,
   input wire reset,
   input wire [7:0] bit_addr,
   input wire [1:0] bit_op,
   input wire bit_wdata,
   input wire bit_rdata,
   input wire bit_addr_valid,
   input wire [7:0] byte_addr,
   input wire byte_wr,
   input wire [7:0] byte_wdata,
   input wire xdata_rd,
   input wire xdata_wr,
   input wire read_strobe_n,
   input wire write_strobe_n,
   input wire shift_data_out,
   input wire shift_data_oe,
   input wire rx_data_pin_out,
   input wire rx_data_pin_oe,
   input wire [1:0] serial_mode,
   input wire [1:0] bank_select,
   input wire [4:0] bank_base,
   input wire timer1_overflow,
   input wire int1_serviced,
   input wire int0_serviced,
   input wire rx_accept,
   input wire rx_byte_done,
   input wire rx_enable,
   input wire timer1_int_req
);
   // All checks run on the core clock and are off during reset.
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Strobes, pin driver, bank base and receive gating.
   AST_RD_STROBE: assert property (xdata_rd |=> !read_strobe_n) else $error("read strobe missing");
   AST_WR_STROBE: assert property (xdata_wr ##1 !xdata_wr |-> !write_strobe_n ##1 write_strobe_n)
      else $error("write strobe not one cycle");
   AST_SHIFT_PIN: assert property ((serial_mode == `BAD_SM_SHIFT && shift_data_oe)
      |=> rx_data_pin_oe && rx_data_pin_out == $past(shift_data_out)) else $error("shift pin not driven");
   AST_PIN_OE: assert property (rx_data_pin_oe |-> $past(serial_mode) == `BAD_SM_SHIFT)
      else $error("pin driven outside shift mode");
   AST_BANK: assert property ((byte_wr && byte_addr == `BAD_SFR_PSW && bit_op == `BAD_OP_NONE)
      |=> bank_select == $past(byte_wdata[4:3]) && bank_base == {$past(byte_wdata[4:3]), 3'b000})
      else $error("bank select wrong");
   AST_RX_GATE: assert property (rx_accept |-> rx_byte_done && rx_enable) else $error("rx accepted");
   // Bit decoding, single-bit writes to the RAM area and the timer 1 overflow flag.
   AST_RAM_VALID: assert property (!bit_addr[7] |=> bit_addr_valid) else $error("ram bit invalid");
   AST_RAM_SET: assert property ((!bit_addr[7] && bit_op == `BAD_OP_SET)
      ##1 ($stable(bit_addr) && bit_op == `BAD_OP_NONE) |=> bit_rdata) else $error("set bit lost");
   AST_RAM_WR: assert property ((!bit_addr[7] && bit_op == `BAD_OP_WRITE)
      ##1 ($stable(bit_addr) && bit_op == `BAD_OP_NONE) |=> bit_rdata == $past(bit_wdata, 2))
      else $error("written bit lost");
   AST_TF1_SET: assert property (timer1_overflow ##1 (bit_op == `BAD_OP_NONE && !int1_serviced
      && !int0_serviced)[*2] ##0 bit_addr == 8'h8f |=> bit_rdata) else $error("timer flag not set");
   // Main scenarios reached.
   COV_RD: cover property (xdata_rd ##1 !read_strobe_n);
   COV_RX: cover property (rx_accept);
   COV_T1: cover property (timer1_int_req);
endmodule // bad_checker
bind bad_bit_decode bad_checker u_chk (.clk, .reset, .bit_addr, .bit_op, .bit_wdata, .bit_rdata, .bit_addr_valid,
   .byte_addr, .byte_wr, .byte_wdata,
   .xdata_rd, .xdata_wr, .read_strobe_n, .write_strobe_n, .shift_data_out, .shift_data_oe, .rx_data_pin_out,
   .rx_data_pin_oe, .serial_mode, .bank_select, .bank_base, .timer1_overflow, .int1_serviced, .int0_serviced,
   .rx_accept, .rx_byte_done, .rx_enable, .timer1_int_req);

// File: tb/bit_address_decode_sfr_test.sv
// Directed tests of the bit-address decoder through its bit and byte ports.
`timescale 1ns/1ps
`include "bad_map.vh"
module bit_address_decode_sfr_test;
   reg clk, reset, bit_wdata, byte_wr, shift_data_out, shift_data_oe;
   reg [7:0] bit_addr, byte_addr, byte_wdata, acc_in;
   reg [1:0] bit_op;
   wire bit_rdata, bit_addr_valid, rx_data_pin_out, rx_data_pin_oe, rx_serial_in, read_strobe_n, write_strobe_n;
   wire timer1_run, timer0_run, rx_enable, rx_accept, tx_ninth_bit, int1_request, int0_request;
   wire timer1_int_req, serial_int_req, timer1_high_prio, serial_high_prio, rx_line;
   wire [7:0] byte_rdata, ev;
   wire [1:0] bank_select, serial_mode;
   wire [4:0] bank_base;
   wire [3:0] arith;
   wire [2:0] pins;
   integer n_mismatch, tests_run, i;
   // The receive line carries the decoder's drive while its pin output enable is set (shift mode with shift_data_oe), else the far side.
   assign rx_line = rx_data_pin_oe ? rx_data_pin_out : pins[2];
   bad_core_model u_core (.clk(clk), .ev(ev), .arith(arith), .pins(pins));
   bad_bit_decode u_dut (.clk(clk), .reset(reset), .bit_addr(bit_addr), .bit_op(bit_op), .bit_wdata(bit_wdata),
      .bit_rdata(bit_rdata), .bit_addr_valid(bit_addr_valid), .byte_addr(byte_addr), .byte_wr(byte_wr),
      .byte_wdata(byte_wdata), .byte_rdata(byte_rdata), .acc_value(acc_in), .arith_update(arith[3]),
      .arith_carry(arith[2]), .arith_aux_carry(arith[1]), .arith_overflow(arith[0]), .timer1_overflow(ev[0]),
      .timer0_overflow(ev[1]), .int1_serviced(ev[2]), .int0_serviced(ev[3]), .ext_int1_n_pin(pins[0]),
      .ext_int0_n_pin(pins[1]), .rx_byte_done(ev[4]), .rx_ninth_bit(ev[5]), .xdata_rd(ev[6]), .xdata_wr(ev[7]),
      .rx_data_pin_in(rx_line), .shift_data_out(shift_data_out), .shift_data_oe(shift_data_oe),
      .rx_data_pin_out(rx_data_pin_out), .rx_data_pin_oe(rx_data_pin_oe), .rx_serial_in(rx_serial_in),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .bank_select(bank_select),
      .bank_base(bank_base), .timer1_run(timer1_run), .timer0_run(timer0_run), .serial_mode(serial_mode),
      .rx_enable(rx_enable), .rx_accept(rx_accept), .tx_ninth_bit(tx_ninth_bit), .int1_request(int1_request),
      .int0_request(int0_request), .timer1_int_req(timer1_int_req), .serial_int_req(serial_int_req),
      .timer1_high_prio(timer1_high_prio), .serial_high_prio(serial_high_prio));
   // ----
   // Access tasks
   // ----
   // Counts a comparison and reports a mismatch at once.
   task cmp(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Bit operation, held for one taken edge; outputs settle before return.
   task bop(input [7:0] a, input [1:0] op, input wd);
      begin
         @(posedge clk) {bit_addr, bit_op, bit_wdata} <= {a, op, wd};
         @(posedge clk) bit_op <= `BAD_OP_NONE;
         #1;
      end
   endtask
   // Bit read; the answer arrives one cycle after the address.
   task bread(input [7:0] a, input e);
      begin
         @(posedge clk) bit_addr <= a;
         @(posedge clk) #1 cmp({7'h0, bit_rdata}, {7'h0, e});
      end
   endtask
   // Byte write pulse.
   task wbyte(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk) {byte_addr, byte_wdata, byte_wr} <= {a, d, 1'b1};
         @(posedge clk) byte_wr <= 1'b0;
         #1;
      end
   endtask
   // Byte read one cycle after the address.
   task rbyte(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk) byte_addr <= a;
         @(posedge clk) #1 cmp(byte_rdata, e);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task report_and_stop;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // ----
   // Clock, watchdog and tests
   // ----
   // Core clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // The tests take well under 1000 cycles; 4000 cycles means a hang.
   initial begin
      #20000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
   // Main sequence.
   initial begin
      {n_mismatch, tests_run} = 0;
      {reset, bit_addr, bit_op, bit_wdata, byte_addr, byte_wr, byte_wdata} = {1'b1, 28'h0};
      {shift_data_out, shift_data_oe, acc_in} = 10'h000;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      wbyte(8'h21, 8'ha5);
      bop(8'h0b, `BAD_OP_SET, 1'b0);
      bop(8'h08, `BAD_OP_CLR, 1'b0);
      bop(8'h0e, `BAD_OP_WRITE, 1'b1);
      rbyte(8'h21, 8'hec);
      wbyte(8'h20, 8'h00);
      bop(8'h00, `BAD_OP_WRITE, 1'b1);
      rbyte(8'h20, 8'h01);
      wbyte(8'h2f, 8'h00);
      bop(8'h7f, `BAD_OP_SET, 1'b0);
      rbyte(8'h2f, 8'h80);
      $display("ram bit test done");
      for (i = 0; i < 4; i = i + 1) begin
         wbyte(`BAD_SFR_PSW, {3'b001, i[1:0], 3'b010});
         cmp({3'h0, bank_base}, {3'b000, i[1:0], 3'b000});
         rbyte(`BAD_SFR_PSW, {3'b001, i[1:0], 3'b000});
      end
      u_core.arith_op(3'b111);
      rbyte(`BAD_SFR_PSW, 8'hfc);
      u_core.arith_op(3'b000);
      rbyte(`BAD_SFR_PSW, 8'h38);
      bop(8'hd7, `BAD_OP_SET, 1'b0);
      bread(8'hd7, 1'b1);
      bop(8'hd5, `BAD_OP_CLR, 1'b0);
      @(posedge clk) acc_in <= 8'h07;
      wbyte(`BAD_SFR_ACC, 8'h07);
      rbyte(`BAD_SFR_PSW, 8'h99);
      bop(8'he7, `BAD_OP_SET, 1'b0);
      rbyte(`BAD_SFR_ACC, 8'h87);
      bread(8'hd0, 1'b0);
      $display("status word test done");
      bop(8'h8e, `BAD_OP_SET, 1'b0);
      bop(8'h8c, `BAD_OP_SET, 1'b0);
      cmp({6'h0, timer1_run, timer0_run}, 8'h03);
      u_core.pulse(0);
      bread(8'h8f, 1'b1);
      wbyte(`BAD_SFR_IEN, 8'h18);
      cmp({7'h0, timer1_int_req}, 8'h00);
      bop(8'haf, `BAD_OP_SET, 1'b0);
      cmp({7'h0, timer1_int_req}, 8'h01);
      wbyte(`BAD_SFR_IEN, 8'hff);
      rbyte(`BAD_SFR_IEN, 8'h9f);
      bop(8'h8a, `BAD_OP_SET, 1'b0);
      u_core.set_pin(0, 1'b0);
      repeat (4) @(posedge clk);
      bread(8'h8b, 1'b1);
      cmp({7'h0, int1_request}, 8'h01);
      u_core.pulse(2);
      bread(8'h8b, 1'b0);
      cmp({7'h0, int1_request}, 8'h00);
      u_core.set_pin(0, 1'b1);
      u_core.pulse(1);
      bread(8'h8d, 1'b1);
      u_core.set_pin(1, 1'b0);
      repeat (3) @(posedge clk);
      #1 cmp({7'h0, int0_request}, 8'h01);
      bread(8'h89, 1'b0);
      u_core.set_pin(1, 1'b1);
      u_core.pulse(3);
      bread(8'h8d, 1'b0);
      $display("timer control test done");
      for (i = 0; i < 4; i = i + 1) begin
         wbyte(`BAD_SFR_SCS, {i[1:0], 6'h18});
         cmp({4'h0, serial_mode, rx_enable, tx_ninth_bit}, {4'h0, i[1:0], 2'b11});
      end
      wbyte(`BAD_SFR_SCS, 8'h70);
      u_core.pulse(4);
      bread(8'h98, 1'b0);
      u_core.set_lvl(5, 1'b1);
      u_core.pulse(4);
      repeat (3) @(posedge clk);
      bread(8'h98, 1'b1);
      cmp({7'h0, serial_int_req}, 8'h01);
      bop(8'h98, `BAD_OP_CLR, 1'b0);
      bread(8'h98, 1'b0);
      wbyte(`BAD_SFR_SCS, 8'h40);
      u_core.pulse(4);
      bread(8'h98, 1'b0);
      u_core.set_pin(2, 1'b0);
      repeat (3) @(posedge clk);
      #1 cmp({7'h0, rx_serial_in}, 8'h00);
      wbyte(`BAD_SFR_SCS, 8'h00);
      @(posedge clk) shift_data_oe <= 1'b1;
      for (i = 0; i < 4; i = i + 1) @(posedge clk) shift_data_out <= i[0];
      repeat (4) @(posedge clk);
      #1 cmp({7'h0, rx_serial_in}, 8'h01);
      @(posedge clk) shift_data_oe <= 1'b0;
      u_core.pulse(6);
      #1 cmp({7'h0, read_strobe_n}, 8'h00);
      u_core.pulse(7);
      #1 cmp({7'h0, write_strobe_n}, 8'h00);
      $display("serial and strobe test done");
      wbyte(`BAD_SFR_IPR, 8'hff);
      rbyte(`BAD_SFR_IPR, 8'h1f);
      cmp({6'h0, serial_high_prio, timer1_high_prio}, 8'h03);
      wbyte(8'hc0, 8'h55);
      rbyte(8'hc0, 8'h00);
      bread(8'hc7, 1'b0);
      cmp({7'h0, bit_addr_valid}, 8'h00);
      $display("priority and unmapped test done");
      report_and_stop;
   end
endmodule // bit_address_decode_sfr_test
